/* rtl/mrtc_regs.svh */
`ifndef MRTC_REGS_SVH
`define MRTC_REGS_SVH

// ==========================================================
// register word indices; byte address is index times four
`define MRTC_IDX_CTRL        6'h01
`define MRTC_IDX_ADDR_HI     6'h02
`define MRTC_IDX_ADDR_LO     6'h03
`define MRTC_IDX_HASH_HI     6'h04
`define MRTC_IDX_HASH_LO     6'h05
`define MRTC_IDX_WAKEUP      6'h0C
`define MRTC_IDX_INT_STATUS  6'h10
`define MRTC_IDX_INT_MASK    6'h11

// ==========================================================
// control word field positions
`define MRTC_BIT_HASH_ONLY      15
`define MRTC_BIT_HASH_PERFECT   13
`define MRTC_BIT_LATE_RETRY     12
`define MRTC_BIT_BROADCAST_REJECT_REJECT   11
`define MRTC_BIT_SINGLE_ATTEMPT 10
`define MRTC_BIT_RESERVED9      9
`define MRTC_BIT_PAD_STRIP      8
// wakeup control field position
`define MRTC_BIT_WAKEUP_ENABLE  2

// ==========================================================
// reset values
`define MRTC_RST_CTRL       32'h0000_0000
`define MRTC_RST_ADDR_HI    16'hFFFF
`define MRTC_RST_ADDR_LO    32'hFFFF_FFFF
`define MRTC_RST_HASH       32'h0000_0000
`define MRTC_RST_INT_MASK   4'h0

// ==========================================================
// interrupt status bit positions
`define MRTC_INT_TX_DONE    0
`define MRTC_INT_RETRY_ERR  1
`define MRTC_INT_LATE_COLL  2
`define MRTC_INT_WAKEUP     3
`define MRTC_INT_WIDTH      4

// ==========================================================
// frame constants
`define MRTC_MIN_LEN_FIELD  16'd46
`define MRTC_HDR_BYTES      16'd14
`define MRTC_MAX_ATTEMPTS   16

`endif

/* rtl/mrtc_pkg.sv */
package mrtc_pkg;
  // ==========================================================
  // transmit retry sequencer states
  typedef enum logic [1:0] {
    MRTC_TX_IDLE,
    MRTC_TX_BUSY
  } mrtc_tx_state_t;

  // station address, first received byte in bits 7:0
  typedef logic [47:0] mrtc_mac_addr_t;
endpackage

/* rtl/mrtc_rx_pad_strip.sv */
`include "mrtc_regs.svh"

module mrtc_rx_pad_strip
  import mrtc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       pad_strip,     // mode from control word
  input  wire logic       in_valid,      // received byte valid
  input  wire logic [7:0] in_data,       // received byte
  input  wire logic       in_last,       // last byte (fcs end)
  output logic            out_valid,     // delivered byte valid
  output logic      [7:0] out_data,      // delivered byte
  output logic            out_last       // last delivered byte
);
  // ==========================================================
  // frame tracking
  logic        mode;           // strip mode latched per frame
  logic [15:0] byte_idx;       // index of current byte
  logic [15:0] len_field;      // length/type field of frame
  logic        short_frame;    // frame carries pad and fcs to drop
  logic        keep;           // current byte is delivered
  logic        cut_last;       // final kept byte of a short frame

  // length field is bytes 12 and 13; it is valid from byte 14 on
  assign short_frame = mode && (byte_idx >= `MRTC_HDR_BYTES) &&
                       (len_field < `MRTC_MIN_LEN_FIELD);
  assign keep     = !short_frame ||
                    (byte_idx < `MRTC_HDR_BYTES + len_field);
  assign cut_last = short_frame &&
                    (byte_idx == `MRTC_HDR_BYTES + len_field - 16'd1);

  // byte counter and mode latch; mode is taken at first byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      byte_idx <= 16'h0000;
      mode     <= 1'b0;
    end else if (in_valid) begin
      if (byte_idx == 16'h0000) begin
        mode <= pad_strip;      // clear mode passes frames as is
      end
      byte_idx <= in_last ? 16'h0000 : byte_idx + 16'd1;
    end
  end

  // capture length field as it passes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      len_field <= 16'h0000;
    end else if (in_valid && byte_idx == 16'd12) begin
      len_field[15:8] <= in_data;
    end else if (in_valid && byte_idx == 16'd13) begin
      len_field[7:0] <= in_data;
    end
  end

  // registered output stage; long frames keep their fcs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid <= 1'b0;
      out_data  <= 8'h00;
      out_last  <= 1'b0;
    end else begin
      out_valid <= in_valid && keep;
      out_data  <= in_data;
      out_last  <= in_valid && keep && (in_last || cut_last);
    end
  end
endmodule

/* rtl/mrtc_tx_retry.sv */
`include "mrtc_regs.svh"

module mrtc_tx_retry
  import mrtc_pkg::*;
#(
  parameter int MAX_ATTEMPTS = `MRTC_MAX_ATTEMPTS
)
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       single_attempt,  // one try per frame
  input  wire logic       late_retry,      // retry on late collision
  input  wire logic       tx_start,        // first attempt begins
  input  wire logic       tx_ok,           // attempt finished cleanly
  input  wire logic       tx_collision,    // collision in window
  input  wire logic       tx_late,         // collision after window
  output logic            tx_retry,        // pulse: send frame again
  output logic            tx_abort,        // pulse: drop, go to next
  output logic            st_valid,        // pulse: status ready
  output logic            st_late,         // late collision seen
  output logic            st_retry_err,    // retry error
  output logic      [4:0] st_attempts      // attempts made
);
  // ==========================================================
  // sequencer
  mrtc_tx_state_t state;
  logic [4:0]     attempts;     // attempts made so far
  logic           late_seen;    // late collision this frame
  logic           coll;         // any collision this cycle
  logic           give_up;      // no further attempt allowed
  logic           abandon_late; // late collision without retry

  assign coll         = tx_collision || tx_late;
  assign abandon_late = tx_late && !late_retry;
  assign give_up = single_attempt ||
                   (attempts >= 5'(MAX_ATTEMPTS));

  // state, attempt count and late flag
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= MRTC_TX_IDLE;
      attempts  <= 5'h00;
      late_seen <= 1'b0;
    end else begin
      case (state)
        MRTC_TX_IDLE: begin
          if (tx_start) begin
            state     <= MRTC_TX_BUSY;
            attempts  <= 5'h01;
            late_seen <= 1'b0;
          end
        end
        MRTC_TX_BUSY: begin
          if (tx_late) begin
            late_seen <= 1'b1;
          end
          if (tx_ok || (coll && (abandon_late || give_up))) begin
            state <= MRTC_TX_IDLE;
          end else if (coll) begin
            attempts <= attempts + 5'h01;  // late retry counts too
          end
        end
        default: state <= MRTC_TX_IDLE;
      endcase
    end
  end

  // action pulses and per-packet status
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_retry     <= 1'b0;
      tx_abort     <= 1'b0;
      st_valid     <= 1'b0;
      st_late      <= 1'b0;
      st_retry_err <= 1'b0;
      st_attempts  <= 5'h00;
    end else begin
      tx_retry <= 1'b0;
      tx_abort <= 1'b0;
      st_valid <= 1'b0;
      if (state == MRTC_TX_BUSY && (tx_ok || coll)) begin
        if (tx_ok) begin
          st_valid     <= 1'b1;
          st_retry_err <= 1'b0;
        end else if (abandon_late) begin
          tx_abort     <= 1'b1;
          st_valid     <= 1'b1;
          st_retry_err <= 1'b0;
        end else if (give_up) begin
          tx_abort     <= 1'b1;
          st_valid     <= 1'b1;
          st_retry_err <= 1'b1;
        end else begin
          tx_retry <= 1'b1;
        end
        st_late     <= late_seen || tx_late;
        st_attempts <= attempts;
      end
    end
  end
endmodule

/* rtl/mrtc_top.sv */
// Functional notes
// - perfect mode accepts only station address match or broadcast
// - hash mode filters multicast through hash table
// - hash only bit in hash mode hashes unicast, else exact
// - late retry set retransmits late collided frame
// - late retry clear abandons late collided frame
// - late collision always recorded in transmit status
// - broadcast reject discards broadcasts, clear forwards them
// - broadcast wakeup frame wakes despite broadcast reject
// - single attempt drops collided frame, retry error unless late collision abandoned
// - otherwise sixteen attempts before retry error
// - pad strip removes pad, fcs below 46
// - length 46 or more delivered with fcs
// - pad strip clear passes frames unmodified
`include "mrtc_regs.svh"

module mrtc_top
  import mrtc_pkg::*;
#(
  parameter int MAX_ATTEMPTS = `MRTC_MAX_ATTEMPTS
)
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  // register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  // receive destination check
  input  wire logic        rx_dest_valid,
  input  wire logic [47:0] rx_dest_addr,
  input  wire logic [5:0]  rx_hash_index,
  input  wire logic        rx_wakeup_match,
  output logic             rx_decision_valid,
  output logic             rx_accept,
  output logic             wake_event,
  // receive byte stream
  input  wire logic        rx_in_valid,
  input  wire logic [7:0]  rx_in_data,
  input  wire logic        rx_in_last,
  output logic             rx_out_valid,
  output logic      [7:0]  rx_out_data,
  output logic             rx_out_last,
  // transmit attempt control
  input  wire logic        tx_start,
  input  wire logic        tx_ok,
  input  wire logic        tx_collision,
  input  wire logic        tx_late,
  output logic             tx_retry,
  output logic             tx_abort,
  output logic             tx_st_valid,
  output logic             tx_st_late,
  output logic             tx_st_retry_err,
  output logic      [4:0]  tx_st_attempts,
  // interrupt
  output logic             irq
);
  // ==========================================================
  // control and configuration registers
  logic        hash_only_select;     // unicast hashed too
  logic        hash_perfect_select;  // hash filter on
  logic        late_collision_retry; // retry after late collision
  logic        broadcast_reject;     // drop broadcast frames
  logic        single_attempt;       // one try per frame
  logic        pad_strip;            // strip pad and fcs
  logic [15:0] addr_hi;              // station address bytes 4,5
  logic [31:0] addr_lo;              // station address bytes 0..3
  logic [31:0] hash_hi;              // hash table bits 63:32
  logic [31:0] hash_lo;              // hash table bits 31:0
  logic        wakeup_frame_enable;  // wakeup detection on
  logic [`MRTC_INT_WIDTH-1:0] int_status; // sticky events
  logic [`MRTC_INT_WIDTH-1:0] int_mask;   // event enables
  logic [`MRTC_INT_WIDTH-1:0] int_events; // this cycle's events

  // write decode
  logic wr_ctrl;
  logic wr_addr_hi;
  logic wr_addr_lo;
  logic wr_hash_hi;
  logic wr_hash_lo;
  logic wr_wakeup;
  logic wr_status;
  logic wr_mask;

  assign wr_ctrl    = reg_we && reg_addr == {`MRTC_IDX_CTRL, 2'b00};
  assign wr_addr_hi = reg_we && reg_addr == {`MRTC_IDX_ADDR_HI, 2'b00};
  assign wr_addr_lo = reg_we && reg_addr == {`MRTC_IDX_ADDR_LO, 2'b00};
  assign wr_hash_hi = reg_we && reg_addr == {`MRTC_IDX_HASH_HI, 2'b00};
  assign wr_hash_lo = reg_we && reg_addr == {`MRTC_IDX_HASH_LO, 2'b00};
  assign wr_wakeup  = reg_we && reg_addr == {`MRTC_IDX_WAKEUP, 2'b00};
  assign wr_status  = reg_we &&
                      reg_addr == {`MRTC_IDX_INT_STATUS, 2'b00};
  assign wr_mask    = reg_we && reg_addr == {`MRTC_IDX_INT_MASK, 2'b00};

  // ==========================================================
  // control word; bit 9 has no storage at all
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hash_only_select     <= 1'b0;
      hash_perfect_select  <= 1'b0;
      late_collision_retry <= 1'b0;
      broadcast_reject     <= 1'b0;
      single_attempt       <= 1'b0;
      pad_strip            <= 1'b0;
    end else if (wr_ctrl) begin
      hash_only_select     <= reg_wdata[`MRTC_BIT_HASH_ONLY];
      hash_perfect_select  <= reg_wdata[`MRTC_BIT_HASH_PERFECT];
      late_collision_retry <= reg_wdata[`MRTC_BIT_LATE_RETRY];
      broadcast_reject     <= reg_wdata[`MRTC_BIT_BROADCAST_REJECT_REJECT];
      single_attempt       <= reg_wdata[`MRTC_BIT_SINGLE_ATTEMPT];
      pad_strip            <= reg_wdata[`MRTC_BIT_PAD_STRIP];
    end
  end

  // station address registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_hi <= `MRTC_RST_ADDR_HI;
      addr_lo <= `MRTC_RST_ADDR_LO;
    end else begin
      if (wr_addr_hi) begin
        addr_hi <= reg_wdata[15:0];
      end
      if (wr_addr_lo) begin
        addr_lo <= reg_wdata;
      end
    end
  end

  // multicast hash table
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hash_hi <= `MRTC_RST_HASH;
      hash_lo <= `MRTC_RST_HASH;
    end else begin
      if (wr_hash_hi) begin
        hash_hi <= reg_wdata;
      end
      if (wr_hash_lo) begin
        hash_lo <= reg_wdata;
      end
    end
  end

  // wakeup control
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wakeup_frame_enable <= 1'b0;
    end else if (wr_wakeup) begin
      wakeup_frame_enable <= reg_wdata[`MRTC_BIT_WAKEUP_ENABLE];
    end
  end

  // ==========================================================
  // receive address filter
  mrtc_mac_addr_t station;     // programmed station address
  logic [63:0]    hash_table;  // full hash table
  logic           is_broadcast_reject;    // all ones destination
  logic           is_mcast;    // group bit set
  logic           exact_hit;   // destination equals station
  logic           hash_hit;    // selected hash bit is set
  logic           next_accept; // filter verdict

  assign station    = {addr_hi, addr_lo};
  assign hash_table = {hash_hi, hash_lo};
  assign is_broadcast_reject   = &rx_dest_addr;
  assign is_mcast   = rx_dest_addr[0];
  assign exact_hit  = rx_dest_addr == station;
  assign hash_hit   = hash_table[rx_hash_index];

  // verdict by destination class
  always_comb begin
    if (is_broadcast_reject) begin
      next_accept = !broadcast_reject;
    end else if (is_mcast) begin
      if (hash_perfect_select) begin
        next_accept = hash_hit;
      end else begin
        next_accept = exact_hit;
      end
    end else if (hash_perfect_select && hash_only_select) begin
      next_accept = hash_hit;
    end else begin
      next_accept = exact_hit;
    end
  end

  // registered verdict and wakeup pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_decision_valid <= 1'b0;
      rx_accept         <= 1'b0;
      wake_event        <= 1'b0;
    end else begin
      rx_decision_valid <= rx_dest_valid;
      rx_accept         <= rx_dest_valid && next_accept;
      // broadcast reject plays no part here
      wake_event        <= rx_dest_valid && rx_wakeup_match &&
                           wakeup_frame_enable;
    end
  end

  // ==========================================================
  // pad and fcs stripping of received bytes
  mrtc_rx_pad_strip u_pad_strip (
    .clk       (clk),
    .arst_n    (arst_n),
    .pad_strip (pad_strip),
    .in_valid  (rx_in_valid),
    .in_data   (rx_in_data),
    .in_last   (rx_in_last),
    .out_valid (rx_out_valid),
    .out_data  (rx_out_data),
    .out_last  (rx_out_last)
  );

  // ==========================================================
  // transmit retry policy
  mrtc_tx_retry #(
    .MAX_ATTEMPTS (MAX_ATTEMPTS)
  ) u_tx_retry (
    .clk            (clk),
    .arst_n         (arst_n),
    .single_attempt (single_attempt),
    .late_retry     (late_collision_retry),
    .tx_start       (tx_start),
    .tx_ok          (tx_ok),
    .tx_collision   (tx_collision),
    .tx_late        (tx_late),
    .tx_retry       (tx_retry),
    .tx_abort       (tx_abort),
    .st_valid       (tx_st_valid),
    .st_late        (tx_st_late),
    .st_retry_err   (tx_st_retry_err),
    .st_attempts    (tx_st_attempts)
  );

  // ==========================================================
  // interrupt status and mask
  always_comb begin
    int_events                       = '0;
    int_events[`MRTC_INT_TX_DONE]    = tx_st_valid;
    int_events[`MRTC_INT_RETRY_ERR]  = tx_st_valid && tx_st_retry_err;
    int_events[`MRTC_INT_LATE_COLL]  = tx_st_valid && tx_st_late;
    int_events[`MRTC_INT_WAKEUP]     = wake_event;
  end

  // sticky bits; a new event beats a write-one clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_status <= '0;
    end else begin
      int_status <= (int_status &
                     ~(wr_status ? reg_wdata[`MRTC_INT_WIDTH-1:0] : '0)) |
                    int_events;
    end
  end

  // mask register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_mask <= `MRTC_RST_INT_MASK;
    end else if (wr_mask) begin
      int_mask <= reg_wdata[`MRTC_INT_WIDTH-1:0];
    end
  end

  assign irq = |(int_status & int_mask);

  // ==========================================================
  // read path; data stands one cycle after the strobe
  logic [31:0] next_rdata;  // selected read word

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (reg_addr)
      {`MRTC_IDX_CTRL, 2'b00}: begin
        next_rdata[`MRTC_BIT_HASH_ONLY]      = hash_only_select;
        next_rdata[`MRTC_BIT_HASH_PERFECT]   = hash_perfect_select;
        next_rdata[`MRTC_BIT_LATE_RETRY]     = late_collision_retry;
        next_rdata[`MRTC_BIT_BROADCAST_REJECT_REJECT]   = broadcast_reject;
        next_rdata[`MRTC_BIT_SINGLE_ATTEMPT] = single_attempt;
        next_rdata[`MRTC_BIT_RESERVED9]      = 1'b0;
        next_rdata[`MRTC_BIT_PAD_STRIP]      = pad_strip;
      end
      {`MRTC_IDX_ADDR_HI, 2'b00}: begin
        next_rdata[15:0] = addr_hi;
      end
      {`MRTC_IDX_ADDR_LO, 2'b00}: begin
        next_rdata = addr_lo;
      end
      {`MRTC_IDX_HASH_HI, 2'b00}: begin
        next_rdata = hash_hi;
      end
      {`MRTC_IDX_HASH_LO, 2'b00}: begin
        next_rdata = hash_lo;
      end
      {`MRTC_IDX_WAKEUP, 2'b00}: begin
        next_rdata[`MRTC_BIT_WAKEUP_ENABLE] = wakeup_frame_enable;
      end
      {`MRTC_IDX_INT_STATUS, 2'b00}: begin
        next_rdata[`MRTC_INT_WIDTH-1:0] = int_status;
      end
      {`MRTC_IDX_INT_MASK, 2'b00}: begin
        next_rdata[`MRTC_INT_WIDTH-1:0] = int_mask;
      end
      default: begin
        next_rdata = 32'h0000_0000;  // unmapped reads zero
      end
    endcase
  end

  // read data register, zero outside a read answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_re ? next_rdata : 32'h0000_0000;
    end
  end
endmodule

/* verification/mrtc_top_asserts.sv */
module mrtc_top_asserts #(
  parameter int MAX_ATTEMPTS = 16
)
(
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic        reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic        rx_dest_valid,
  input wire logic        rx_decision_valid,
  input wire logic        rx_accept,
  input wire logic        wake_event,
  input wire logic        rx_in_valid,
  input wire logic        rx_out_valid,
  input wire logic        tx_retry,
  input wire logic        tx_abort,
  input wire logic        tx_st_valid,
  input wire logic [4:0]  tx_st_attempts
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // one clock domain for every property
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  chk_read_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
  chk_decide_lat: assert property (rx_dest_valid |=> rx_decision_valid)
    else $error("filter decision missing");
  chk_decide_src: assert property (rx_decision_valid |-> $past(rx_dest_valid))
    else $error("filter decision without request");
  chk_accept_qual: assert property (rx_accept |-> rx_decision_valid)
    else $error("accept outside decision");
  chk_wake_src: assert property (wake_event |-> $past(rx_dest_valid))
    else $error("wake without request");
  chk_byte_src: assert property (rx_out_valid |-> $past(rx_in_valid))
    else $error("byte without input");
  chk_abort_ends: assert property (tx_abort |-> !tx_retry && tx_st_valid)
    else $error("abort without status");
  chk_attempt_range: assert property (tx_st_valid |->
    tx_st_attempts inside {[1:MAX_ATTEMPTS]})
    else $error("attempt count out of range");
  chk_retry_pulse: assert property (tx_retry |=> !tx_retry)
    else $error("retry not a pulse");
  // main scenarios reached
  cover property (tx_abort);
  cover property (rx_accept);
  cover property (wake_event && !rx_accept);
endmodule

/* verification/mrtc_phy_model.sv */
module mrtc_phy_model (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       tx_start,
  input  wire logic       tx_retry,
  input  wire logic [4:0] n_coll,    // collisions before success
  input  wire logic       use_late,  // collisions come late
  input  wire logic [3:0] gap,       // attempt length in cycles
  output logic            tx_ok,
  output logic            tx_collision,
  output logic            tx_late
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       busy;  // attempt on the wire
  logic [3:0] cnt;   // cycles left in attempt
  logic [4:0] left;  // collisions still to give
  // ==========================================================
  // one outcome pulse per attempt, after a variable delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {busy, cnt, left, tx_ok, tx_collision, tx_late} <= '0;
    end else begin
      {tx_ok, tx_collision, tx_late} <= 3'b000;
      if (tx_start && !busy) begin
        busy <= 1'b1;
        cnt  <= gap;
        left <= n_coll;
      end else if (tx_retry) begin
        busy <= 1'b1;
        cnt  <= gap;
      end else if (busy && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (busy) begin
        busy <= 1'b0;
        tx_ok <= (left == 5'h00);
        tx_late <= (left != 5'h00) && use_late;
        tx_collision <= (left != 5'h00) && !use_late;
        left <= left - (left != 5'h00);
      end
    end
  end
endmodule

/* verification/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // stimulus, observed outputs, expectation queues
  logic        clk = 1'b0, arst_n = 1'b0, rd_pend = 1'b0;
  logic        reg_we = 1'b0, reg_re = 1'b0, tx_start = 1'b0;
  logic        rx_dest_valid = 1'b0, rx_wakeup_match = 1'b0;
  logic        rx_in_valid = 1'b0, rx_in_last = 1'b0, use_late = 1'b0;
  logic [3:0]  gap = 4'h0;
  logic [4:0]  n_coll = 5'h00, tx_st_attempts;
  logic [5:0]  rx_hash_index = 6'h00;
  logic [7:0]  reg_addr = 8'h00, rx_in_data = 8'h00, rx_out_data;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  logic [47:0] rx_dest_addr = 48'h0, uni, mc;
  logic [63:0] r;
  logic        rx_decision_valid, rx_accept, wake_event, irq, tx_ok;
  logic        rx_out_valid, rx_out_last, tx_collision, tx_late;
  logic        tx_retry, tx_abort, tx_st_valid, tx_st_late, tx_st_retry_err;
  int          seed = 32'h4ba167d0, fail_count = 0, checked = 0, cyc = 0;
  logic [31:0] qr[$], qt[$], qf[$], qb[$];
  localparam logic [47:0] STATION = 48'h6655_4433_2210;
  localparam logic [47:0] ALL_ONES = 48'hFFFF_FFFF_FFFF;
  always #5 clk = ~clk;
  mrtc_top dut (.*);
  mrtc_phy_model phy (.*);
  // ==========================================================
  // comparison, closing report, hang guard
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (qr.size() + qt.size() + qf.size() + qb.size() != 0)
      fail_count++;
    if (fail_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    rd_pend <= reg_re;
    if (cyc == 10000) begin
      fail_count++;
      complete_run();
    end
  end
  // watcher: oldest note against each result that appears
  always @(negedge clk) begin
    if (rd_pend)
      check(reg_rdata, qr.pop_front());
    if (rx_decision_valid)
      check({wake_event, rx_accept}, qf.pop_front());
    if (tx_st_valid)
      check({tx_st_late, tx_st_retry_err, tx_st_attempts},
        qt.pop_front());
    if (rx_out_valid)
      check({rx_out_last, rx_out_data}, qb.pop_front());
  end
  // ==========================================================
  // drivers: register port, filter, transmit, byte stream
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {reg_we, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    qr.push_back(e);
    @(posedge clk);
    {reg_re, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_re <= 1'b0;
  endtask
  task automatic filt(input logic [31:0] c, input logic [47:0] d,
                      input logic [5:0] i, input logic w, input logic [1:0] e);
    wr(8'h04, c);
    qf.push_back(e);
    {rx_dest_valid, rx_dest_addr, rx_hash_index} <= {1'b1, d, i};
    rx_wakeup_match <= w;
    @(posedge clk);
    rx_dest_valid <= 1'b0;
  endtask
  task automatic txf(input logic [31:0] c, input logic [4:0] n,
                     input logic l, input logic [6:0] e);
    wr(8'h04, c);
    {n_coll, use_late, gap} <= {n, l, 4'($random(seed))};
    qt.push_back(e);
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    for (int i = 0; i < 600 && tx_st_valid !== 1'b1; i++) @(negedge clk);
    @(posedge clk);
  endtask
  task automatic frame(input logic s, input logic [15:0] len, input int n);
    logic [7:0] b;
    logic       cut;
    cut = s && len < 16'd46;
    wr(8'h04, {23'h0, s, 8'h00});
    for (int i = 0; i < n; i++) begin
      b = (i == 12) ? len[15:8] : (i == 13) ? len[7:0] : 8'($random(seed));
      {rx_in_valid, rx_in_data, rx_in_last} <= {1'b1, b, i == n - 1};
      if (!cut || i < 14 + len)
        qb.push_back({cut ? i == 13 + len : i == n - 1, b});
      @(posedge clk);
    end
    {rx_in_valid, rx_in_last} <= 2'b00;
    repeat (3) @(posedge clk);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0000_FFFF);
    rd(8'h0C, 32'hFFFF_FFFF);
    rd(8'h7C, 32'h0);
    wr(8'h04, 32'h0000_3F00);
    rd(8'h04, 32'h0000_3D00);
    wr(8'h0C, STATION[31:0]);
    wr(8'h08, {16'h0, STATION[47:32]});
    wr(8'h14, 32'h0000_0020);
    txf(32'h400, 5'd1, 1'b0, 7'h21);
    txf(32'h0, 5'd20, 1'b0, 7'h30);
    txf(32'h0, 5'd3, 1'b0, 7'h04);
    txf(32'h0, 5'd1, 1'b1, 7'h41);
    txf(32'h1000, 5'd1, 1'b1, 7'h42);
    rd(8'h40, 32'h7);
    check(irq, 1'b0);
    wr(8'h44, 32'h2);
    #1 check(irq, 1'b1);
    wr(8'h40, 32'h2);
    #1 check(irq, 1'b0);
    rd(8'h40, 32'h5);
    wr(8'h40, 32'hF);
    r = {$random(seed), $random(seed)};
    uni = {r[47:1], 1'b0};
    mc = {r[47:1], 1'b1};
    filt(32'h0, STATION, 6'd5, 1'b0, 2'b01);
    filt(32'h0, uni, 6'd5, 1'b0, 2'b00);
    filt(32'h0, ALL_ONES, 6'd0, 1'b0, 2'b01);
    filt(32'h800, ALL_ONES, 6'd0, 1'b0, 2'b00);
    filt(32'h2000, mc, 6'd5, 1'b0, 2'b01);
    filt(32'h2000, mc, 6'd6, 1'b0, 2'b00);
    filt(32'h2000, STATION, 6'd6, 1'b0, 2'b01);
    filt(32'h2000, uni, 6'd5, 1'b0, 2'b00);
    filt(32'hA000, uni, 6'd5, 1'b0, 2'b01);
    wr(8'h30, 32'h4);
    filt(32'h800, ALL_ONES, 6'd0, 1'b1, 2'b10);
    rd(8'h40, 32'h8);
    #1 check(irq, 1'b0);
    frame(1'b1, 16'd2, 64);
    frame(1'b1, 16'd45, 64);
    frame(1'b1, 16'd46, 64);
    frame(1'b0, 16'd2, 64);
    complete_run();
  end
endmodule
bind mrtc_top mrtc_top_asserts #(.MAX_ATTEMPTS(MAX_ATTEMPTS)) u_chk (.*);
